// ### logic/rrw_params.svh
`ifndef RRW_PARAMS_SVH
`define RRW_PARAMS_SVH

// Clock and the common 1 ms time base.
`define RRW_CLK_HZ 100000000
`define RRW_TICK_MS 1
`define RRW_CYCLES_PER_MS ((`RRW_CLK_HZ / 1000) * `RRW_TICK_MS)

// System-reset delay: step 0 is 0 ms, step n is 2**(n-1) ms, top step 16.
`define RRW_DELAY_SEL_MAX 5'h10

// Watchdog initial wait: step 0 is 0 ms, step n is 100 ms * 2**(n-1).
`define RRW_WAIT_BASE_MS 21'h000064

// Pulse width and watchdog timeout limits, in ms.
`define RRW_WIDTH_MIN_MS 16'h0001
`define RRW_WIDTH_MAX_MS 16'h7e00

// Reset values of the registered sys_reset_o and timeout_output_o outputs.
`define RRW_SYSRST_RESET 1'b1
`define RRW_TIMEOUT_RESET 1'b0

`endif

// ### logic/rrw_pkg.sv
`default_nettype none
package rrw_pkg;

  typedef struct packed {
    logic [4:0] delay_sel;
    logic pulse_mode;
    logic [15:0] pulse_width_ms;
    logic wd_enable;
    logic wd_tied;
    logic [3:0] wd_init_sel;
    logic [15:0] wd_timeout_ms;
    logic wd_pulse_action;
    logic wd_track_release;
  } rrw_cfg_t;

  typedef struct packed {
    logic rails_good;
    logic released;
    logic wd_running;
    logic wd_expired;
  } rrw_stat_t;

  typedef enum logic [2:0] {
    RST_WAIT,
    RST_DELAY,
    RST_PULSE,
    RST_RUN,
    RST_OFFDLY,
    RST_RECOV
  } rrw_rst_state_t;

  typedef enum logic [1:0] {
    WD_OFF,
    WD_INIT,
    WD_COUNT,
    WD_EXPIRED
  } rrw_wd_state_t;

endpackage
`default_nettype wire

// ### logic/rrw_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rrw_tick_gen #(
  parameter int CYCLES = 100000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  output logic tick_o
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 32'h1;
    if (cnt_q >= 32'(CYCLES - 1))
    begin
      cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end

endmodule
`default_nettype wire

// ### logic/rrw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rrw_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ### logic/rrw_rail_reset_and_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "rrw_params.svh"
module rrw_rail_reset_and_watchdog
  import rrw_pkg::*;
#(
  parameter int RAILS = 10,
  parameter int CYCLES_PER_MS = `RRW_CYCLES_PER_MS
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [RAILS-1:0] rail_good_i,
  input wire logic [RAILS-1:0] rail_select_i,
  input wire rrw_cfg_t cfg_i,
  input wire logic kick_input_i,
  input wire logic kick_cmd_i,
  output logic sys_reset_o,
  output logic timeout_output_o,
  output rrw_stat_t stat_o
);

  function automatic logic [15:0] rst_delay_ms(input logic [4:0] sel);
    logic [4:0] s;
    s = (sel > `RRW_DELAY_SEL_MAX) ? `RRW_DELAY_SEL_MAX : sel;
    if (s == 5'h0)
      return 16'h0;
    return 16'h1 << (s - 5'h1);
  endfunction

  function automatic logic [20:0] wd_wait_ms(input logic [3:0] sel);
    if (sel == 4'h0)
      return 21'h0;
    return `RRW_WAIT_BASE_MS << (sel - 4'h1);
  endfunction

  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    if (v < `RRW_WIDTH_MIN_MS)
      return `RRW_WIDTH_MIN_MS;
    if (v > `RRW_WIDTH_MAX_MS)
      return `RRW_WIDTH_MAX_MS;
    return v;
  endfunction

  logic tick;
  logic [RAILS-1:0] rail_good_s;
  logic kick_s;
  logic kick_prev_q;
  logic kick_pin_evt;
  logic kick_evt;
  logic all_good;
  logic wd_active;

  rrw_tick_gen #(
    .CYCLES(CYCLES_PER_MS)
  ) u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  rrw_sync #(
    .W(RAILS + 1)
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i({kick_input_i, rail_good_i}),
    .q_o({kick_s, rail_good_s})
  );

  assign kick_pin_evt = kick_s ^ kick_prev_q;
  assign kick_evt = kick_pin_evt | kick_cmd_i;
  assign all_good = &(rail_good_s | ~rail_select_i);

  // System-reset sequencer.
  rrw_rst_state_t rst_q;
  rrw_rst_state_t rst_d;
  logic [15:0] rst_cnt_q;
  logic [15:0] rst_cnt_d;
  logic sys_reset_d;
  logic wd_fire_q;

  always_comb
  begin
    rst_d = rst_q;
    rst_cnt_d = rst_cnt_q;
    sys_reset_d = sys_reset_o;
    unique case (rst_q)
      RST_WAIT:
      begin
        sys_reset_d = ~cfg_i.pulse_mode;
        if (all_good)
        begin
          rst_d = RST_DELAY;
          rst_cnt_d = rst_delay_ms(cfg_i.delay_sel);
        end
      end
      RST_DELAY:
      begin
        sys_reset_d = ~cfg_i.pulse_mode;
        if (!all_good)
          rst_d = RST_WAIT;
        else if (rst_cnt_q == 16'h0)
        begin
          if (cfg_i.pulse_mode)
          begin
            rst_d = RST_PULSE;
            rst_cnt_d = clamp_ms(cfg_i.pulse_width_ms);
            sys_reset_d = 1'b1;
          end
          else
          begin
            rst_d = RST_RUN;
            sys_reset_d = 1'b0;
          end
        end
        else if (tick)
          rst_cnt_d = rst_cnt_q - 16'h1;
      end
      RST_PULSE:
      begin
        sys_reset_d = 1'b1;
        if (tick)
        begin
          if (rst_cnt_q <= 16'h1)
          begin
            rst_d = RST_RUN;
            sys_reset_d = 1'b0;
          end
          else
            rst_cnt_d = rst_cnt_q - 16'h1;
        end
      end
      RST_RUN:
      begin
        sys_reset_d = 1'b0;
        if (!all_good)
        begin
          if (cfg_i.pulse_mode)
            rst_d = RST_WAIT;
          else
          begin
            rst_d = RST_OFFDLY;
            rst_cnt_d = rst_delay_ms(cfg_i.delay_sel);
          end
        end
        else if (wd_fire_q)
        begin
          rst_d = RST_RECOV;
          rst_cnt_d = clamp_ms(cfg_i.pulse_width_ms);
          sys_reset_d = 1'b1;
        end
      end
      RST_OFFDLY:
      begin
        sys_reset_d = 1'b0;
        if (all_good)
          rst_d = RST_RUN;
        else if (rst_cnt_q == 16'h0)
        begin
          rst_d = RST_WAIT;
          sys_reset_d = 1'b1;
        end
        else if (tick)
          rst_cnt_d = rst_cnt_q - 16'h1;
      end
      RST_RECOV:
      begin
        sys_reset_d = 1'b1;
        if (!all_good)
        begin
          rst_d = RST_WAIT;
          sys_reset_d = ~cfg_i.pulse_mode;
        end
        else if ((cfg_i.wd_track_release && kick_evt) || (tick && rst_cnt_q <= 16'h1))
        begin
          rst_d = RST_RUN;
          sys_reset_d = 1'b0;
        end
        else if (tick)
          rst_cnt_d = rst_cnt_q - 16'h1;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rst_q <= RST_WAIT;
      rst_cnt_q <= 16'h0;
      sys_reset_o <= `RRW_SYSRST_RESET;
    end
    else
    begin
      rst_q <= rst_d;
      rst_cnt_q <= rst_cnt_d;
      sys_reset_o <= sys_reset_d;
    end
  end

  // Watchdog. Tied mode only runs while the sequencer is in RST_RUN, so a slow boot never expires it.
  assign wd_active = cfg_i.wd_enable && (!cfg_i.wd_tied || rst_q == RST_RUN);

  rrw_wd_state_t wd_q;
  rrw_wd_state_t wd_d;
  logic [20:0] wd_cnt_q;
  logic [20:0] wd_cnt_d;
  logic wd_fire_d;
  logic timeout_d;
  rrw_stat_t stat_d;

  always_comb
  begin
    wd_d = wd_q;
    wd_cnt_d = wd_cnt_q;
    wd_fire_d = 1'b0;
    if (!wd_active)
      wd_d = WD_OFF;
    else
    begin
      unique case (wd_q)
        WD_OFF:
        begin
          wd_d = WD_INIT;
          wd_cnt_d = wd_wait_ms(cfg_i.wd_init_sel);
        end
        WD_INIT:
        begin
          if (kick_evt || wd_cnt_q == 21'h0)
          begin
            wd_d = WD_COUNT;
            wd_cnt_d = {5'h0, clamp_ms(cfg_i.wd_timeout_ms)};
          end
          else if (tick)
            wd_cnt_d = wd_cnt_q - 21'h1;
        end
        WD_COUNT:
        begin
          if (kick_evt)
            wd_cnt_d = {5'h0, clamp_ms(cfg_i.wd_timeout_ms)};
          else if (tick)
          begin
            if (wd_cnt_q <= 21'h1)
            begin
              wd_d = WD_EXPIRED;
              wd_fire_d = cfg_i.wd_pulse_action;
            end
            else
              wd_cnt_d = wd_cnt_q - 21'h1;
          end
        end
        WD_EXPIRED:
        begin
          if (kick_evt)
          begin
            wd_d = WD_COUNT;
            wd_cnt_d = {5'h0, clamp_ms(cfg_i.wd_timeout_ms)};
          end
        end
      endcase
    end
    timeout_d = (wd_d == WD_EXPIRED) && !cfg_i.wd_pulse_action;
    stat_d.rails_good = all_good;
    stat_d.released = (rst_d == RST_RUN) || (rst_d == RST_OFFDLY);
    stat_d.wd_running = (wd_d == WD_INIT) || (wd_d == WD_COUNT);
    stat_d.wd_expired = (wd_d == WD_EXPIRED);
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wd_q <= WD_OFF;
      wd_cnt_q <= 21'h0;
      wd_fire_q <= 1'b0;
      kick_prev_q <= 1'b0;
      timeout_output_o <= `RRW_TIMEOUT_RESET;
      stat_o <= '0;
    end
    else
    begin
      wd_q <= wd_d;
      wd_cnt_q <= wd_cnt_d;
      wd_fire_q <= wd_fire_d;
      kick_prev_q <= kick_s;
      timeout_output_o <= timeout_d;
      stat_o <= stat_d;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_wait_holds_reset: assert property (
    rst_q == RST_WAIT && !cfg_i.pulse_mode && $stable(cfg_i.pulse_mode) |-> sys_reset_o)
    else $error("level reset not held while rails are not good");

  chk_delay_release: assert property (
    rst_q == RST_DELAY && rst_cnt_q == 16'h0 && all_good && !cfg_i.pulse_mode |=> !sys_reset_o && rst_q == RST_RUN)
    else $error("level reset not released after delay");

  chk_pulse_start: assert property (
    rst_q == RST_DELAY && rst_cnt_q == 16'h0 && all_good && cfg_i.pulse_mode
    |=> sys_reset_o && rst_q == RST_PULSE && rst_cnt_q == clamp_ms($past(cfg_i.pulse_width_ms)))
    else $error("reset pulse not started with programmed width");

  chk_delay_load: assert property (
    rst_q == RST_WAIT && all_good |=> rst_q == RST_DELAY && rst_cnt_q == rst_delay_ms($past(cfg_i.delay_sel)))
    else $error("reset delay not loaded from selection");

  chk_off_delay: assert property (
    rst_q == RST_OFFDLY && !all_good && rst_cnt_q == 16'h0 |=> sys_reset_o ##1 rst_q == RST_WAIT || rst_q == RST_DELAY)
    else $error("level reset not reasserted after shared delay");

  chk_fire_recover: assert property (
    wd_fire_q && rst_q == RST_RUN && all_good |=> rst_q == RST_RECOV && sys_reset_o)
    else $error("watchdog expiry did not toggle system reset");

  chk_kick_restart: assert property (
    wd_active && wd_q == WD_COUNT && kick_evt |=> wd_q == WD_COUNT && wd_cnt_q == {5'h0, clamp_ms($past(cfg_i.wd_timeout_ms))})
    else $error("kick did not restart timeout count");

  chk_timeout_range: assert property (
    wd_q == WD_COUNT |-> wd_cnt_q >= 21'h1 && wd_cnt_q <= {5'h0, `RRW_WIDTH_MAX_MS})
    else $error("watchdog count outside programmable range");

  chk_expired_holds: assert property (
    wd_q == WD_EXPIRED && wd_active && !kick_evt |=> wd_q == WD_EXPIRED)
    else $error("watchdog left expiry without a kick");

  chk_timeout_pin: assert property (
    wd_q == WD_EXPIRED && !cfg_i.wd_pulse_action && $stable(cfg_i.wd_pulse_action) |-> timeout_output_o)
    else $error("timeout pin not asserted on expiry");

  chk_init_wait: assert property (
    wd_active && wd_q == WD_OFF |=> wd_q == WD_INIT && wd_cnt_q == wd_wait_ms($past(cfg_i.wd_init_sel)))
    else $error("initial wait not loaded");

  chk_tick_spacing: assert property (
    tick |=> !tick)
    else $error("time base ticks back to back");

  cov_pulse_done: cover property (rst_q == RST_PULSE ##1 rst_q == RST_RUN);
  cov_wd_expired: cover property (wd_q == WD_COUNT ##1 wd_q == WD_EXPIRED);
  cov_recovery: cover property (rst_q == RST_RECOV ##1 rst_q == RST_RUN);
  cov_pin_kick: cover property (wd_q == WD_EXPIRED && kick_pin_evt);

endmodule
`default_nettype wire

// ### verif/rrw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rrw_host_model #(
  parameter int KICK_GAP = 5
) (
  input wire logic clock_i,
  input wire logic pin_run_i,
  input wire logic pin_once_i,
  input wire logic cmd_once_i,
  output logic kick_input_o,
  output logic kick_cmd_o
);
  int gap_cnt = 0;
  initial
  begin
    kick_input_o = 1'b0;
    kick_cmd_o = 1'b0;
  end
  // Kicks land well inside a 2 ms timeout, so a live host never lets the timer run out.
  always @(negedge clock_i)
  begin
    kick_cmd_o <= cmd_once_i;
    gap_cnt <= (gap_cnt == KICK_GAP - 1) ? 0 : gap_cnt + 1;
    if ((pin_run_i && gap_cnt == 0) || pin_once_i)
    begin
      kick_input_o <= ~kick_input_o;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rrw_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [9:0] rail_sel = 10'h005;
  logic [9:0] good_sel = 10'h000;
  logic [9:0] noise = 10'h000;
  rrw_cfg_t cfg = '0;
  rrw_cfg_t c;
  rrw_stat_t stat;
  logic kick_pin, kick_cmd, sys_reset, timeout_out;
  logic pin_run = 1'b0;
  logic pin_once = 1'b0;
  logic cmd_once = 1'b0;
  logic [1:0] notes[$];
  logic [1:0] last_seen;
  int errors = 0;
  int check_count = 0;

  always #5 clock_i = ~clock_i;

  rrw_rail_reset_and_watchdog #(.RAILS(10), .CYCLES_PER_MS(10)) i_rrw_rail_reset_and_watchdog (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .rail_good_i((noise & ~rail_sel) | (good_sel & rail_sel)),
    .rail_select_i(rail_sel),
    .cfg_i(cfg),
    .kick_input_i(kick_pin),
    .kick_cmd_i(kick_cmd),
    .sys_reset_o(sys_reset),
    .timeout_output_o(timeout_out),
    .stat_o(stat)
  );

  rrw_host_model i_rrw_host_model (
    .clock_i(clock_i),
    .pin_run_i(pin_run),
    .pin_once_i(pin_once),
    .cmd_once_i(cmd_once),
    .kick_input_o(kick_pin),
    .kick_cmd_o(kick_cmd)
  );

  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Unselected rails flicker at random every cycle; they must never move the outputs.
  // The seed is given in the process that draws the values, so the sequence is repeatable.
  initial
  begin
    void'($urandom(32'h6567));
    forever
    begin
      @(negedge clock_i);
      noise <= 10'($urandom);
    end
  end

  // Outputs are looked at just after the edge that launches them, so no note and change share a time step.
  always @(posedge clock_i)
  begin
    #1;
    if (!rst_n_i)
      last_seen = {sys_reset, timeout_out};
    else if ({sys_reset, timeout_out} !== last_seen)
    begin
      last_seen = {sys_reset, timeout_out};
      if (notes.size() == 0)
        check("unexpected output change", last_seen, ~last_seen);
      else
        check("output pair", last_seen, notes.pop_front());
    end
  end

  task automatic restart(input rrw_cfg_t nc);
    rst_n_i <= 1'b0;
    cfg <= nc;
    good_sel <= 10'h000;
    repeat (3) @(negedge clock_i);
    rst_n_i <= 1'b1;
  endtask

  task automatic hold(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic expect_out(input logic [1:0] val, input int limit);
    int n;
    n = 0;
    notes.push_back(val);
    while ({sys_reset, timeout_out} !== val && n < limit)
    begin
      @(negedge clock_i);
      n++;
    end
    check("settled outputs", {sys_reset, timeout_out}, val);
  endtask

  task automatic kick(input logic by_pin);
    if (by_pin)
      pin_once <= 1'b1;
    else
      cmd_once <= 1'b1;
    @(negedge clock_i);
    pin_once <= 1'b0;
    cmd_once <= 1'b0;
  endtask

  initial
  begin
    c = '0;
    c.delay_sel = 5'h03;
    @(negedge clock_i);
    restart(c);
    hold(20);
    good_sel <= 10'h005;
    hold(27);
    expect_out(2'b00, 25);
    check("released flag", {stat.rails_good, stat.released}, 2'b11);
    good_sel <= 10'h001;
    hold(27);
    expect_out(2'b10, 25);
    $display("Level mode test done");

    c = '0;
    c.pulse_mode = 1'b1;
    c.delay_sel = 5'h02;
    c.pulse_width_ms = 16'h0003;
    restart(c);
    expect_out(2'b00, 3);
    good_sel <= 10'h005;
    hold(8);
    expect_out(2'b10, 25);
    hold(17);
    expect_out(2'b00, 25);
    $display("Pulse mode test done");

    c = '0;
    c.wd_enable = 1'b1;
    c.wd_tied = 1'b1;
    c.wd_init_sel = 4'h1;
    c.wd_timeout_ms = 16'h0002;
    c.pulse_width_ms = 16'h0001;
    restart(c);
    hold(60);
    cfg.wd_tied <= 1'b0;
    hold(950);
    expect_out(2'b11, 100);
    check("expired flag", {stat.wd_running, stat.wd_expired}, 2'b01);
    hold(50);
    kick(1'b0);
    expect_out(2'b10, 4);
    check("running flag", {stat.wd_running, stat.wd_expired}, 2'b10);
    pin_run <= 1'b1;
    hold(100);
    pin_run <= 1'b0;
    hold(8);
    expect_out(2'b11, 40);
    kick(1'b1);
    expect_out(2'b10, 6);
    $display("Timeout pin test done");

    c = '0;
    c.wd_enable = 1'b1;
    c.wd_tied = 1'b1;
    c.wd_pulse_action = 1'b1;
    c.wd_timeout_ms = 16'h0002;
    c.pulse_width_ms = 16'h0003;
    restart(c);
    good_sel <= 10'h005;
    expect_out(2'b00, 15);
    hold(8);
    expect_out(2'b10, 30);
    hold(17);
    expect_out(2'b00, 25);
    cfg.wd_track_release <= 1'b1;
    expect_out(2'b10, 40);
    kick(1'b0);
    expect_out(2'b00, 4);
    $display("Reset pulse action test done");
    end_of_test();
  end

  // The whole sequence needs under 1700 cycles; the limit of 10000 cycles means a hang.
  initial
  begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
